// file: design/dram_timing_pkg.sv
// Purpose: shared constants for the dram interface timing block
// Assumes: one bus state is STATE_TICKS cycles of the 125 MHz clk
// Notes: register offsets are byte addresses on the plain register port
//
// Functional notes
// - enable bit set: area 1 becomes dram space with dram signalling.
// - mux enable set: row then column address on the same pins.
// - row shift field picks an 8, 9 or 10 bit row shift.
// - shift 00: address bits 23..8 on pins 15..0 in the row phase.
// - column phase: address bits 21..0 unshifted on the same pins.
// - pitch chosen per cycle type: cpu read/write, dma read/write.
// - pitch bit 0: short pitch, column phase exactly one state.
// - pitch bit 1: long pitch, column phase two states plus waits.
// - short pitch column strobe high 50% (duty 0) or 35% (duty 1).
// - row strobe precharge lasts one state, or two when selected.
// - wait bit 0: column ends after one state, wait input ignored.
// - wait bit 1: sample wait before second column state, repeat while low.
// - cpu read pitch 1: refresh gets refresh wait count extra states.
package dram_timing_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int RADDR_W = 8;
  localparam logic [7:0] BUS_CTRL_OFS = 8'h00;
  localparam logic [7:0] DRAM_CTRL_OFS = 8'h04;
  localparam logic [7:0] WAIT_ONE_OFS = 8'h08;
  localparam logic [7:0] WAIT_TWO_OFS = 8'h0c;
  localparam logic [7:0] REFRESH_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // field positions
  localparam int SPACE_EN_BIT = 0;
  localparam int MUX_EN_BIT = 0;
  localparam int SHIFT_LO_BIT = 1;
  localparam int SHIFT_HI_BIT = 2;
  localparam int DUTY_BIT = 3;
  localparam int PRECHARGE_BIT = 4;
  localparam int READ_PITCH_BIT = 0;
  localparam int WRITE_PITCH_BIT = 1;
  localparam int RWAIT_LO_BIT = 0;
  localparam int RWAIT_HI_BIT = 1;

  // reset values
  localparam logic [15:0] BUS_CTRL_RST = 16'h0000;
  localparam logic [15:0] DRAM_CTRL_RST = 16'h0000;
  localparam logic [15:0] WAIT_ONE_RST = 16'h0000;
  localparam logic [15:0] WAIT_TWO_RST = 16'h0000;
  localparam logic [15:0] REFRESH_RST = 16'h0000;

  // ----------------------------------------------------------------
  // timing and encodings
  // ----------------------------------------------------------------
  localparam int STATE_TICKS_DEFAULT = 20;
  localparam int DUTY_WIDE_PCT = 50;
  localparam int DUTY_NARROW_PCT = 35;
  localparam int PRE_SHORT_STATES = 1;
  localparam int PRE_LONG_STATES = 2;
  localparam logic [2:0] DRAM_AREA = 3'h1;
  localparam logic [1:0] SHIFT_8 = 2'h0;
  localparam logic [1:0] SHIFT_9 = 2'h1;
  localparam logic [1:0] SHIFT_10 = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROW = 3'b001,
    ST_COL1 = 3'b010,
    ST_COL2 = 3'b011,
    ST_RCAS = 3'b100,
    ST_RRAS = 3'b101,
    ST_PRE = 3'b110,
    ST_CWAIT = 3'b111
  } state_type;

endpackage

// file: design/dram_interface_timing.sv
// Purpose: dram access sequencer for external area 1
// Assumes: one request at a time, issued only while busy is low
// Notes: outputs are registered; sub-state duty uses STATE_TICKS clocks
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module dram_interface_timing #(
  parameter int STATE_TICKS = dram_timing_pkg::STATE_TICKS_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // internal bus request
  input wire logic req,
  input wire logic req_write,
  input wire logic req_dma,
  input wire logic req_refresh,
  input wire logic [26:0] req_addr,
  output logic busy,
  output logic done,
  output logic not_dram,
  // dram pins
  output logic [21:0] dram_addr,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  input wire logic wait_n
);

  localparam int DUTY_WIDE = STATE_TICKS * dram_timing_pkg::DUTY_WIDE_PCT / 100;
  localparam int DUTY_NARROW =
    STATE_TICKS * dram_timing_pkg::DUTY_NARROW_PCT / 100;
  localparam logic [7:0] LAST_TICK = 8'(STATE_TICKS - 1);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] bus_control_reg;
  logic [15:0] dram_area_control_reg;
  logic [15:0] wait_control_reg_one;
  logic [15:0] wait_control_reg_two;
  logic [15:0] refresh_control_reg;
  logic dram_space_enable;
  logic addr_mux_enable;
  logic [1:0] row_shift;
  logic column_strobe_duty_select;
  logic precharge_length_select;
  logic cpu_read_pitch_select;
  logic cpu_write_pitch_select;
  logic dma_read_pitch_select;
  logic dma_write_pitch_select;
  logic [1:0] refresh_wait_count;

  assign dram_space_enable = bus_control_reg[dram_timing_pkg::SPACE_EN_BIT];
  assign addr_mux_enable = dram_area_control_reg[dram_timing_pkg::MUX_EN_BIT];
  assign row_shift = {dram_area_control_reg[dram_timing_pkg::SHIFT_HI_BIT],
                      dram_area_control_reg[dram_timing_pkg::SHIFT_LO_BIT]};
  assign column_strobe_duty_select =
    dram_area_control_reg[dram_timing_pkg::DUTY_BIT];
  assign precharge_length_select =
    dram_area_control_reg[dram_timing_pkg::PRECHARGE_BIT];
  assign cpu_read_pitch_select =
    wait_control_reg_one[dram_timing_pkg::READ_PITCH_BIT];
  assign cpu_write_pitch_select =
    wait_control_reg_one[dram_timing_pkg::WRITE_PITCH_BIT];
  assign dma_read_pitch_select =
    wait_control_reg_two[dram_timing_pkg::READ_PITCH_BIT];
  assign dma_write_pitch_select =
    wait_control_reg_two[dram_timing_pkg::WRITE_PITCH_BIT];
  assign refresh_wait_count =
    {refresh_control_reg[dram_timing_pkg::RWAIT_HI_BIT],
     refresh_control_reg[dram_timing_pkg::RWAIT_LO_BIT]};

  dram_timing_pkg::state_type state_reg, state_next;
  logic [7:0] tick_reg, tick_next;
  logic [2:0] scnt_reg, scnt_next;
  logic [23:0] lat_addr_reg;
  logic lat_write_reg;
  logic long_reg, long_next;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_control_reg <= dram_timing_pkg::BUS_CTRL_RST;
      dram_area_control_reg <= dram_timing_pkg::DRAM_CTRL_RST;
      wait_control_reg_one <= dram_timing_pkg::WAIT_ONE_RST;
      wait_control_reg_two <= dram_timing_pkg::WAIT_TWO_RST;
      refresh_control_reg <= dram_timing_pkg::REFRESH_RST;
    end else if (reg_write) begin
      unique case (reg_addr)
        dram_timing_pkg::BUS_CTRL_OFS: bus_control_reg <= reg_wdata;
        dram_timing_pkg::DRAM_CTRL_OFS: dram_area_control_reg <= reg_wdata;
        dram_timing_pkg::WAIT_ONE_OFS: wait_control_reg_one <= reg_wdata;
        dram_timing_pkg::WAIT_TWO_OFS: wait_control_reg_two <= reg_wdata;
        dram_timing_pkg::REFRESH_OFS: refresh_control_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        dram_timing_pkg::BUS_CTRL_OFS: reg_rdata <= bus_control_reg;
        dram_timing_pkg::DRAM_CTRL_OFS: reg_rdata <= dram_area_control_reg;
        dram_timing_pkg::WAIT_ONE_OFS: reg_rdata <= wait_control_reg_one;
        dram_timing_pkg::WAIT_TWO_OFS: reg_rdata <= wait_control_reg_two;
        dram_timing_pkg::REFRESH_OFS: reg_rdata <= refresh_control_reg;
        dram_timing_pkg::STATUS_OFS: reg_rdata <= {12'h000, busy, state_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // address mapping
  // ----------------------------------------------------------------
  // pins above the shifted row fall to zero; the dram ignores them
  function automatic logic [21:0] row_pins(input logic [23:0] a,
                                           input logic [1:0] sh);
    logic [23:0] s;
    s = a >> 8;
    if (sh == dram_timing_pkg::SHIFT_9) begin
      s = a >> 9;
    end else if (sh == dram_timing_pkg::SHIFT_10) begin
      s = a >> 10;
    end
    return s[21:0];
  endfunction

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  logic last_tick;
  logic accept;
  logic is_dram;
  logic [23:0] src_addr;
  logic src_write;
  logic [2:0] rras_states;
  logic [2:0] pre_states;
  logic [21:0] dram_addr_next;
  logic ras_n_next;
  logic cas_n_next;
  logic we_n_next;

  assign last_tick = (tick_reg == LAST_TICK);
  assign is_dram = req_refresh ||
    (req_addr[26:24] == dram_timing_pkg::DRAM_AREA);
  assign accept = req && (state_reg == dram_timing_pkg::ST_IDLE) &&
    dram_space_enable && is_dram;
  assign src_addr = (state_reg == dram_timing_pkg::ST_IDLE) ?
    req_addr[23:0] : lat_addr_reg;
  assign src_write = (state_reg == dram_timing_pkg::ST_IDLE) ?
    req_write : lat_write_reg;
  assign rras_states = cpu_read_pitch_select ?
    {1'b0, refresh_wait_count} : 3'h0;
  assign pre_states = precharge_length_select ?
    3'(dram_timing_pkg::PRE_LONG_STATES - 1) :
    3'(dram_timing_pkg::PRE_SHORT_STATES - 1);

  always_comb begin
    unique case ({req_dma, req_write})
      2'b00: long_next = cpu_read_pitch_select;
      2'b01: long_next = cpu_write_pitch_select;
      2'b10: long_next = dma_read_pitch_select;
      2'b11: long_next = dma_write_pitch_select;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    scnt_next = scnt_reg;
    tick_next = last_tick ? 8'h00 : tick_reg + 8'h01;
    unique case (state_reg)
      dram_timing_pkg::ST_IDLE: begin
        tick_next = 8'h00;
        scnt_next = 3'h0;
        if (accept) begin
          state_next = req_refresh ? dram_timing_pkg::ST_RCAS :
            dram_timing_pkg::ST_ROW;
        end
      end
      dram_timing_pkg::ST_ROW: begin
        if (last_tick) state_next = dram_timing_pkg::ST_COL1;
      end
      dram_timing_pkg::ST_COL1: begin
        if (last_tick) begin
          if (!long_reg) begin
            state_next = dram_timing_pkg::ST_PRE;
          end else if (wait_n) begin
            state_next = dram_timing_pkg::ST_COL2;
          end else begin
            state_next = dram_timing_pkg::ST_CWAIT;
          end
        end
      end
      dram_timing_pkg::ST_CWAIT: begin
        if (last_tick && wait_n) begin
          state_next = dram_timing_pkg::ST_COL2;
        end
      end
      dram_timing_pkg::ST_COL2: begin
        if (last_tick) state_next = dram_timing_pkg::ST_PRE;
      end
      dram_timing_pkg::ST_RCAS: begin
        if (last_tick) state_next = dram_timing_pkg::ST_RRAS;
      end
      dram_timing_pkg::ST_RRAS: begin
        if (last_tick) begin
          if (scnt_reg == rras_states) begin
            state_next = dram_timing_pkg::ST_PRE;
            scnt_next = 3'h0;
          end else begin
            scnt_next = scnt_reg + 3'h1;
          end
        end
      end
      dram_timing_pkg::ST_PRE: begin
        if (last_tick) begin
          if (scnt_reg == pre_states) begin
            state_next = dram_timing_pkg::ST_IDLE;
          end else begin
            scnt_next = scnt_reg + 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= dram_timing_pkg::ST_IDLE;
      tick_reg <= 8'h00;
      scnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      scnt_reg <= scnt_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lat_addr_reg <= 24'h000000;
      lat_write_reg <= 1'b0;
      long_reg <= 1'b0;
    end else if (accept) begin
      lat_addr_reg <= req_addr[23:0];
      lat_write_reg <= req_write && !req_refresh;
      long_reg <= long_next;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  always_comb begin
    dram_addr_next = dram_addr;
    ras_n_next = 1'b1;
    cas_n_next = 1'b1;
    we_n_next = 1'b1;
    unique case (state_next)
      dram_timing_pkg::ST_IDLE: ;
      dram_timing_pkg::ST_ROW: begin
        ras_n_next = 1'b0;
        dram_addr_next = addr_mux_enable ?
          row_pins(src_addr, row_shift) : src_addr[21:0];
      end
      dram_timing_pkg::ST_COL1: begin
        ras_n_next = 1'b0;
        we_n_next = !src_write;
        dram_addr_next = src_addr[21:0];
        // short pitch: strobe high for the first part of the state
        if (!long_reg) begin
          cas_n_next = column_strobe_duty_select ?
            (tick_next < 8'(DUTY_NARROW)) :
            (tick_next < 8'(DUTY_WIDE));
        end
      end
      dram_timing_pkg::ST_CWAIT, dram_timing_pkg::ST_COL2: begin
        ras_n_next = 1'b0;
        cas_n_next = 1'b0;
        we_n_next = !src_write;
        dram_addr_next = src_addr[21:0];
      end
      dram_timing_pkg::ST_RCAS: cas_n_next = 1'b0;
      dram_timing_pkg::ST_RRAS: begin
        ras_n_next = 1'b0;
        cas_n_next = 1'b0;
      end
      dram_timing_pkg::ST_PRE: ;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dram_addr <= 22'h000000;
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      we_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      dram_addr <= dram_addr_next;
      ras_n <= ras_n_next;
      cas_n <= cas_n_next;
      we_n <= we_n_next;
      busy <= (state_next != dram_timing_pkg::ST_IDLE);
    end
  end

  // a refused request is answered at once so the master never hangs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
      not_dram <= 1'b0;
    end else begin
      done <= (req && state_reg == dram_timing_pkg::ST_IDLE && !accept) ||
        (state_reg == dram_timing_pkg::ST_PRE &&
         state_next == dram_timing_pkg::ST_IDLE);
      not_dram <= req && state_reg == dram_timing_pkg::ST_IDLE && !accept;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  function automatic logic [2:0] phase_of(input logic [2:0] s);
    return (s == dram_timing_pkg::ST_CWAIT || s == dram_timing_pkg::ST_COL2)
      ? dram_timing_pkg::ST_COL1 : s;
  endfunction

  logic [15:0] dwell_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dwell_reg <= 16'h0000;
    end else if (phase_of(state_next) == phase_of(state_reg)) begin
      dwell_reg <= dwell_reg + 16'h0001;
    end else begin
      dwell_reg <= 16'h0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_space_off: assert property (
    req && !busy && state_reg == dram_timing_pkg::ST_IDLE &&
    !dram_space_enable |=> ras_n && cas_n && done && not_dram
  ) else $error("dram signalling while dram space disabled");

  a_row_pins: assert property (
    state_reg == dram_timing_pkg::ST_ROW && addr_mux_enable |->
    dram_addr == row_pins(lat_addr_reg, row_shift) && !ras_n
  ) else $error("row address not shifted as selected");

  a_col_pins: assert property (
    state_reg == dram_timing_pkg::ST_COL2 |->
    dram_addr == lat_addr_reg[21:0] && !cas_n
  ) else $error("column address not unshifted");

  a_nomux_hold: assert property (
    state_reg == dram_timing_pkg::ST_ROW && !addr_mux_enable |->
    dram_addr == lat_addr_reg[21:0] ##1 dram_addr == lat_addr_reg[21:0]
  ) else $error("address changed with multiplexing off");

  a_short_len: assert property (
    state_reg == dram_timing_pkg::ST_COL1 &&
    state_next == dram_timing_pkg::ST_PRE |->
    !long_reg && dwell_reg == 16'(STATE_TICKS - 1)
  ) else $error("short pitch column phase not one state");

  a_long_len: assert property (
    state_reg == dram_timing_pkg::ST_COL2 &&
    state_next == dram_timing_pkg::ST_PRE |->
    long_reg && dwell_reg >= 16'(2 * STATE_TICKS - 1)
  ) else $error("long pitch column phase shorter than two states");

  a_duty_high: assert property (
    state_reg == dram_timing_pkg::ST_COL1 && !long_reg |->
    cas_n == (column_strobe_duty_select ? tick_reg < 8'(DUTY_NARROW) :
              tick_reg < 8'(DUTY_WIDE))
  ) else $error("column strobe duty wrong");

  a_pre_len: assert property (
    state_reg == dram_timing_pkg::ST_PRE &&
    state_next == dram_timing_pkg::ST_IDLE |->
    dwell_reg == 16'(STATE_TICKS * (precharge_length_select ? 2 : 1) - 1)
    ##1 busy == 1'b0
  ) else $error("precharge length wrong");

  a_wait_ignore: assert property (
    state_reg == dram_timing_pkg::ST_COL1 && !long_reg |->
    state_next != dram_timing_pkg::ST_CWAIT
  ) else $error("wait state inserted in short pitch");

  a_wait_hold: assert property (
    (state_reg == dram_timing_pkg::ST_COL1 ||
     state_reg == dram_timing_pkg::ST_CWAIT) && long_reg && last_tick &&
    !wait_n |=> state_reg == dram_timing_pkg::ST_CWAIT && !cas_n
  ) else $error("wait request low not honoured");

  a_refresh_wait: assert property (
    state_reg == dram_timing_pkg::ST_RRAS &&
    state_next == dram_timing_pkg::ST_PRE |->
    dwell_reg == 16'(STATE_TICKS * (32'(rras_states) + 1) - 1)
  ) else $error("refresh wait states wrong");

endmodule

// file: bench/dram_device_model.sv
// Purpose: behavioural dram standing on the far side of the sequencer
// Assumes: ST matches the clocks per bus state of the design
// Notes: records what a real part would latch on each strobe edge
`timescale 1ns/1ps
module dram_device_model #(
  parameter int ST = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // dram pins
  input wire logic [21:0] dram_addr,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  output logic wait_n,
  // bench control and observation
  input wire logic [3:0] waits,
  output logic [21:0] row_seen,
  output logic [21:0] col_seen,
  output logic [7:0] high_cnt,
  output logic [7:0] we_cnt
);
  // ----------------------------------------------------------------
  // strobe capture and wait generation
  // ----------------------------------------------------------------
  logic [11:0] cnt;
  logic ras_d;
  logic cas_d;

  // a slow part holds wait low over the first sampling edges; release
  // lands mid-state so the sampling point is never marginal
  assign wait_n = !(waits != 4'h0 && !ras_n &&
                    int'(cnt) < (int'(waits) + 1) * ST + ST / 2);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 12'h000;
      ras_d <= 1'b1;
      cas_d <= 1'b1;
      row_seen <= 22'h000000;
      col_seen <= 22'h000000;
      high_cnt <= 8'h00;
      we_cnt <= 8'h00;
    end else begin
      ras_d <= ras_n;
      cas_d <= cas_n;
      cnt <= ras_n ? 12'h000 : cnt + 12'h001;
      if (ras_d && !ras_n) begin
        row_seen <= dram_addr;
        high_cnt <= 8'(cas_n);
        we_cnt <= 8'(!we_n);
      end else begin
        if (!ras_n && cas_n) begin
          high_cnt <= high_cnt + 8'h01;
        end
        if (!we_n) begin
          we_cnt <= we_cnt + 8'h01;
        end
      end
      if (cas_d && !cas_n && !ras_n) begin
        col_seen <= dram_addr;
      end
    end
  end
endmodule

// file: bench/dram_interface_timing_tb.sv
// Purpose: self-checking bench for dram_interface_timing
// Assumes: 125 MHz clk, registers at the package offsets
// Notes: 20 clocks per state keeps the 35% column duty exact
`timescale 1ns/1ps
module dram_interface_timing_tb;
  localparam int ST = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic req_dma = 1'b0;
  logic req_refresh = 1'b0;
  logic [26:0] req_addr = 27'h0000000;
  logic [3:0] waits = 4'h0;
  logic busy, done, not_dram, ras_n, cas_n, we_n, wait_n;
  logic [15:0] reg_rdata, rd;
  logic [21:0] dram_addr, row_seen, col_seen;
  logic [7:0] high_cnt, we_cnt;
  int n_fail = 0;
  int checks = 0;
  int lat;

  always #4 clk = ~clk;

  dram_interface_timing #(.STATE_TICKS(ST)) dut (.clk(clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .req(req), .req_write(req_write), .req_dma(req_dma),
    .req_refresh(req_refresh), .req_addr(req_addr), .busy(busy),
    .done(done), .not_dram(not_dram), .dram_addr(dram_addr),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .wait_n(wait_n));

  dram_device_model #(.ST(ST)) dev (.clk(clk), .resetn(resetn),
    .dram_addr(dram_addr), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .wait_n(wait_n), .waits(waits), .row_seen(row_seen),
    .col_seen(col_seen), .high_cnt(high_cnt), .we_cnt(we_cnt));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cfg(input logic [15:0] dctl, w1, w2, rf);
    reg_wr(dram_timing_pkg::BUS_CTRL_OFS, 16'h0001);
    reg_wr(dram_timing_pkg::DRAM_CTRL_OFS, dctl);
    reg_wr(dram_timing_pkg::WAIT_ONE_OFS, w1);
    reg_wr(dram_timing_pkg::WAIT_TWO_OFS, w2);
    reg_wr(dram_timing_pkg::REFRESH_OFS, rf);
  endtask

  // one request; lat counts clocks from the taking edge to done
  task automatic acc(input logic w, dma, rf, input logic [26:0] a);
    @(posedge clk);
    req <= 1'b1;
    req_write <= w;
    req_dma <= dma;
    req_refresh <= rf;
    req_addr <= a;
    @(posedge clk);
    req <= 1'b0;
    // done may stand only in the cycle after the taking edge: look at once
    lat = 1;
    #1;
    while (done !== 1'b1 && lat < 400) begin
      @(posedge clk);
      #1 lat++;
    end
    if (done !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask

  function automatic int elat(int cols, int w, int pre);
    return 1 + ST * (1 + cols + w + pre);
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] rst [5] = '{dram_timing_pkg::BUS_CTRL_RST,
      dram_timing_pkg::DRAM_CTRL_RST, dram_timing_pkg::WAIT_ONE_RST,
      dram_timing_pkg::WAIT_TWO_RST, dram_timing_pkg::REFRESH_RST};
    // control registers sit at a word stride from offset 0
    for (int i = 0; i < 5; i++) begin
      reg_rd(8'(4 * i), rd);
      chk(rd, rst[i]);
      reg_wr(8'(4 * i), 16'ha5c3 ^ 16'(i));
      reg_rd(8'(4 * i), rd);
      chk(rd, 16'ha5c3 ^ 16'(i));
      reg_wr(8'(4 * i), 16'h0000);
    end
    reg_wr(8'h20, 16'hffff);
    reg_rd(8'h20, rd);
    chk(rd, 16'h0000);
    reg_wr(dram_timing_pkg::STATUS_OFS, 16'hffff);
    reg_rd(dram_timing_pkg::STATUS_OFS, rd);
    chk(rd, 16'h0000);
    $display("test registers done");
  endtask

  task automatic t_refused;
    acc(1'b0, 1'b0, 1'b0, 27'h1000040);
    chk(lat, 1);
    chk(not_dram, 1'b1);
    cfg(16'h0001, '0, '0, '0);
    acc(1'b0, 1'b0, 1'b0, 27'h2000040);
    chk(not_dram, 1'b1);
    acc(1'b0, 1'b0, 1'b0, 27'h1000040);
    chk(not_dram, 1'b0);
    chk(busy, 1'b0);
    $display("test area decode done");
  endtask

  task automatic t_mux;
    logic [26:0] a = 27'h1abcdef;
    for (int s = 0; s < 3; s++) begin
      cfg(16'h0001 | 16'(s << 1), '0, '0, '0);
      acc(1'b0, 1'b0, 1'b0, a);
      chk(row_seen, 22'(a[23:0] >> (8 + s)));
      chk(col_seen, a[21:0]);
    end
    cfg('0, '0, '0, '0);
    acc(1'b1, 1'b0, 1'b0, a);
    chk(row_seen, a[21:0]);
    chk(col_seen, a[21:0]);
    $display("test address multiplex done");
  endtask

  task automatic t_pitch;
    for (int sel = 0; sel < 4; sel++) begin
      cfg(16'h0001, 16'(sel < 2 ? 1 << sel : 0),
          16'(sel > 1 ? 1 << (sel - 2) : 0), '0);
      for (int t = 0; t < 4; t++) begin
        acc(t[0], t[1], 1'b0, 27'h1000100);
        chk(lat, elat(t == sel ? 2 : 1, 0, 1));
        chk(we_cnt != 8'h00, t[0]);
      end
    end
    $display("test pitch select done");
  endtask

  task automatic t_wait;
    cfg(16'h0001, 16'h0001, '0, '0);
    for (int w = 0; w < 4; w++) begin
      waits = 4'(w);
      acc(1'b0, 1'b0, 1'b0, 27'h1000200);
      chk(lat, elat(2, w, 1));
    end
    waits = 4'h2;
    acc(1'b1, 1'b0, 1'b0, 27'h1000200);
    chk(lat, elat(1, 0, 1));
    waits = 4'h0;
    $display("test wait insertion done");
  endtask

  task automatic t_duty_pre;
    for (int d = 0; d < 2; d++) begin
      // the narrow duty is legal: clk is well above the 10 MHz floor
      cfg(16'h0001 | 16'(d << 3) | 16'(d << 4), '0, '0, '0);
      acc(1'b0, 1'b0, 1'b0, 27'h1000300);
      chk(high_cnt, ST + ST * (d ? dram_timing_pkg::DUTY_NARROW_PCT
          : dram_timing_pkg::DUTY_WIDE_PCT) / 100);
      chk(lat, elat(1, 0, 1 + d));
    end
    $display("test duty and precharge done");
  endtask

  task automatic t_refresh;
    logic [15:0] w1 [3] = '{16'h0000, 16'h0001, 16'h0001};
    logic [15:0] rf [3] = '{16'h0003, 16'h0003, 16'h0001};
    int ew [3] = '{0, 3, 1};
    for (int i = 0; i < 3; i++) begin
      cfg(16'h0001, w1[i], '0, rf[i]);
      acc(1'b0, 1'b0, 1'b1, 27'h1000000);
      chk(lat, elat(1, ew[i], 1));
    end
    $display("test refresh wait done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_refused();
    t_mux();
    t_pitch();
    t_wait();
    t_duty_pre();
    t_refresh();
    finish_test();
  end
endmodule
